// ===== design/hbad_top.sv
`include "hbad_defines.svh"

// Function
// - Fixed default processor decode applies from reset until maps programmed.
// - Addresses 80000000-8001FFFF go to PCI/ISA I/O space.
// - Addresses FEF80000-FEF8FFFF select memory controller registers.
// - Addresses FEFF0000-FEFFFFFF select host bridge registers.
// - Low 2GB and gaps between windows select no target unless an enabled outbound map decoder hits.
// - Top 1MB maps to flash bank A when boot bank select clear.
// - Top 1MB maps to flash bank B when boot bank select set.
// - Reset disables all PCI-side map decoders.
// - Four processor-to-PCI and four PCI-to-processor map decoders.
// - 32-bit addresses and 64-bit data path.
// - Dual address cycles are neither generated nor accepted.
// - Config cycles use address register at CF8 then data at CFC.
// - Runs with processor bus up to 100MHz, PCI up to 33MHz.
module hbad_top
	import hbad_pkg::*;
(
	// Clock and reset.
	input  wire logic                      i_clk,
	input  wire logic                      i_resetn,
	// Processor bus request.
	input  wire hbad_pkg::hbad_req_t       i_cpu,
	// PCI side request.
	input  wire hbad_pkg::hbad_req_t       i_pci,
	// Map decoder programming.
	input  wire logic                      i_map_we,
	input  wire logic                      i_map_dir,
	input  wire logic [1:0]                i_map_idx,
	input  wire hbad_pkg::hbad_map_t       i_map_wdata,
	// Processor side routing.
	output hbad_pkg::hbad_route_t          o_cpu_route,
	output logic                           o_cpu_ack,
	output logic                           o_cpu_err,
	output logic [63:0]                    o_cpu_rdata,
	output logic [63:0]                    o_pci_wdata,
	// PCI side routing.
	output logic                           o_pci_sel,
	output logic [31:0]                    o_pci_addr,
	output logic                           o_pci_err,
	// State visible to software.
	output logic                           o_boot_bank_select,
	output logic                           o_map_active
);
	import hbad_pkg::*;

	localparam int CPU_PERIOD_NS = 1000 / `HBAD_CPU_MHZ;

	hbad_map_t [3:0] out_maps;
	hbad_map_t [3:0] in_maps;
	logic [31:0]     config_address_select;
	logic            boot_bank_select;
	logic            maps_programmed;
	logic            out_hit;
	logic [31:0]     out_addr;
	logic            in_hit;
	logic [31:0]     in_addr;
	hbad_route_t     next_route;
	logic            next_err;
	logic [63:0]     next_rdata;

	function automatic logic in_range(input logic [31:0] a,
		input logic [31:0] lo, input logic [31:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	function automatic logic is_word(input logic [31:0] a,
		input logic [31:0] ofs);
		is_word = in_range(a, `HBAD_IO_BASE, `HBAD_IO_LAST) &&
			((a - `HBAD_IO_BASE) == ofs);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Map decoders for both directions.

	hbad_map_decoder u_out_dec (
		.i_addr (i_cpu.addr),
		.i_maps (out_maps),
		.o_hit  (out_hit),
		.o_addr (out_addr)
	);

	hbad_map_decoder u_in_dec (
		.i_addr (i_pci.addr),
		.i_maps (in_maps),
		.o_hit  (in_hit),
		.o_addr (in_addr)
	);

	// Reset clears every decoder; software programs each one singly.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			out_maps <= '0;
			in_maps  <= '0;
		end else if (i_map_we) begin
			if (i_map_dir)
				in_maps[i_map_idx]  <= i_map_wdata;
			else
				out_maps[i_map_idx] <= i_map_wdata;
		end
	end

	// Default decode holds until any outbound decoder is enabled.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			maps_programmed <= 1'b0;
		else if (i_map_we && !i_map_dir && i_map_wdata.en)
			maps_programmed <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Register writes from the processor bus.

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			config_address_select <= `HBAD_CFG_RESET;
		end else if (i_cpu.valid && i_cpu.write && !i_cpu.dac &&
			is_word(i_cpu.addr, `HBAD_CFG_ADDR_OFS)) begin
			config_address_select <= i_cpu.wdata[31:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			boot_bank_select <= 1'b0;
		end else if (i_cpu.valid && i_cpu.write && !i_cpu.dac &&
			i_cpu.addr == (`HBAD_MCU_BASE + 32'(`HBAD_BOOT_SEL_OFS))) begin
			boot_bank_select <= i_cpu.wdata[`HBAD_BOOT_SEL_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Processor address decode.

	always_comb begin
		next_route           = '0;
		next_route.tgt       = HBAD_TGT_NONE;
		next_route.addr      = i_cpu.addr;
		next_route.cfg_sel   = config_address_select;
		next_err             = 1'b0;
		next_rdata           = '0;
		if (i_cpu.valid) begin
			if (i_cpu.dac) begin
				next_err = 1'b1;
			end else if (in_range(i_cpu.addr, `HBAD_IO_BASE,
				`HBAD_IO_LAST)) begin
				next_route.tgt = HBAD_TGT_IO;
				next_route.addr = i_cpu.addr - `HBAD_IO_BASE;
				next_route.cfg_cycle = is_word(i_cpu.addr,
					`HBAD_CFG_DATA_OFS) && config_address_select[`HBAD_CFG_EN_BIT];
				if (is_word(i_cpu.addr, `HBAD_CFG_ADDR_OFS))
					next_rdata = {32'h0, config_address_select};
			end else if (in_range(i_cpu.addr, `HBAD_MCU_BASE,
				`HBAD_MCU_LAST)) begin
				next_route.tgt = HBAD_TGT_MCU;
				if (i_cpu.addr == (`HBAD_MCU_BASE +
					32'(`HBAD_BOOT_SEL_OFS)))
					next_rdata = {63'h0, boot_bank_select};
			end else if (in_range(i_cpu.addr, `HBAD_HB_BASE,
				`HBAD_HB_LAST)) begin
				next_route.tgt = HBAD_TGT_HB;
				if (i_cpu.addr == (`HBAD_HB_BASE +
					32'(`HBAD_MAP_CTL_OFS)))
					next_rdata = {63'h0, maps_programmed};
			end else if (in_range(i_cpu.addr, `HBAD_BOOT_BASE,
				`HBAD_BOOT_LAST)) begin
				next_route.tgt = boot_bank_select ? HBAD_TGT_ROMB
					: HBAD_TGT_ROMA;
				next_route.addr = i_cpu.addr - `HBAD_BOOT_BASE;
			end else if (maps_programmed && out_hit) begin
				next_route.tgt = HBAD_TGT_MAP;
				next_route.addr = out_addr;
			end else begin
				next_err = 1'b1;
			end
			next_route.sel = (next_route.tgt != HBAD_TGT_NONE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs.

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_cpu_route <= '0;
			o_cpu_ack   <= 1'b0;
			o_cpu_err   <= 1'b0;
			o_cpu_rdata <= '0;
			o_pci_wdata <= '0;
		end else begin
			o_cpu_route <= next_route;
			o_cpu_ack   <= i_cpu.valid && !next_err;
			o_cpu_err   <= next_err;
			o_cpu_rdata <= next_rdata;
			o_pci_wdata <= i_cpu.wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pci_sel  <= 1'b0;
			o_pci_addr <= '0;
			o_pci_err  <= 1'b0;
		end else begin
			o_pci_sel  <= i_pci.valid && !i_pci.dac && in_hit;
			o_pci_addr <= in_addr;
			o_pci_err  <= i_pci.valid && (i_pci.dac || !in_hit);
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_boot_bank_select <= 1'b0;
			o_map_active       <= 1'b0;
		end else begin
			o_boot_bank_select <= boot_bank_select;
			o_map_active       <= maps_programmed;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.

	sequence s_io_req;
		i_cpu.valid && !i_cpu.dac &&
			in_range(i_cpu.addr, `HBAD_IO_BASE, `HBAD_IO_LAST);
	endsequence

	chk_io_window_route: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		s_io_req |=> o_cpu_route.tgt == HBAD_TGT_IO && o_cpu_route.sel)
		else $error("I/O window not routed to I/O space.");

	chk_mcu_window: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		i_cpu.valid && !i_cpu.dac && i_cpu.addr[31:16] == 16'hfef8
		|=> o_cpu_route.tgt == HBAD_TGT_MCU)
		else $error("Memory controller window misrouted.");

	chk_hb_window: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		i_cpu.valid && !i_cpu.dac && i_cpu.addr[31:16] == 16'hfeff
		|=> o_cpu_route.tgt == HBAD_TGT_HB)
		else $error("Host bridge window misrouted.");

	chk_low_unmapped: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		i_cpu.valid && !i_cpu.addr[31] && !maps_programmed
		|=> !o_cpu_route.sel && o_cpu_err)
		else $error("Low range selected a target.");

	chk_boot_bank: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		i_cpu.valid && !i_cpu.dac && i_cpu.addr[31:20] == 12'hfff
		|=> o_cpu_route.tgt == (o_boot_bank_select ? HBAD_TGT_ROMB
			: HBAD_TGT_ROMA))
		else $error("Boot range bank choice wrong.");

	chk_pci_maps_off: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		$rose(i_resetn) ##0 i_pci.valid |=> !o_pci_sel)
		else $error("PCI window responded after reset.");

	chk_no_dac: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		(i_cpu.valid && i_cpu.dac) |=> o_cpu_err && !o_cpu_route.sel)
		else $error("Dual address cycle was accepted.");

	chk_err_no_sel: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		o_cpu_err |-> !o_cpu_route.sel && !o_cpu_ack)
		else $error("Error raised alongside a target select.");

	chk_cfg_latch: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		i_cpu.valid && i_cpu.write && !i_cpu.dac &&
			is_word(i_cpu.addr, `HBAD_CFG_ADDR_OFS)
		|=> ##1 o_cpu_route.cfg_sel == $past(i_cpu.wdata[31:0], 2))
		else $error("Config address register did not latch.");

	initial assert (CPU_PERIOD_NS == 10)
		else $error("Processor clock period differs from 10 ns.");

endmodule

// ===== design/hbad_defines.svh
`ifndef HBAD_DEFINES_SVH
`define HBAD_DEFINES_SVH

`define HBAD_IO_BASE       32'h8000_0000
`define HBAD_IO_LAST       32'h8001_ffff
`define HBAD_MCU_BASE      32'hfef8_0000
`define HBAD_MCU_LAST      32'hfef8_ffff
`define HBAD_HB_BASE       32'hfeff_0000
`define HBAD_HB_LAST       32'hfeff_ffff
`define HBAD_BOOT_BASE     32'hfff0_0000
`define HBAD_BOOT_LAST     32'hffff_ffff
`define HBAD_CFG_ADDR_OFS  32'h0000_0cf8
`define HBAD_CFG_DATA_OFS  32'h0000_0cfc
`define HBAD_BOOT_SEL_OFS  16'h0050
`define HBAD_BOOT_SEL_BIT  0
`define HBAD_MAP_CTL_OFS   16'h0060
`define HBAD_CFG_EN_BIT    31
`define HBAD_CFG_RESET     32'h0000_0000
`define HBAD_NUM_MAPS      4
`define HBAD_CPU_MHZ       100
`define HBAD_PCI_MHZ       33

`endif

// ===== design/hbad_pkg.sv
package hbad_pkg;

	typedef enum logic [2:0] {
		HBAD_TGT_NONE = 3'b000,
		HBAD_TGT_IO   = 3'b001,
		HBAD_TGT_MCU  = 3'b010,
		HBAD_TGT_HB   = 3'b011,
		HBAD_TGT_ROMA = 3'b100,
		HBAD_TGT_ROMB = 3'b101,
		HBAD_TGT_MAP  = 3'b110
	} hbad_tgt_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        dac;
		logic [31:0] addr;
		logic [63:0] wdata;
		logic [7:0]  be;
	} hbad_req_t;

	typedef struct packed {
		logic        en;
		logic [15:0] base;
		logic [15:0] last;
		logic [15:0] offs;
	} hbad_map_t;

	typedef struct packed {
		logic        sel;
		hbad_tgt_t   tgt;
		logic [31:0] addr;
		logic        cfg_cycle;
		logic [31:0] cfg_sel;
	} hbad_route_t;

endpackage

// ===== design/hbad_map_decoder.sv
`include "hbad_defines.svh"

module hbad_map_decoder
	import hbad_pkg::*;
(
	// Address in and map table.
	input  wire logic [31:0]                    i_addr,
	input  wire hbad_pkg::hbad_map_t [3:0]      i_maps,
	// Hit result.
	output logic                                o_hit,
	output logic [31:0]                         o_addr
);

	// Lowest numbered enabled window that holds the address wins.
	always_comb begin
		o_hit  = 1'b0;
		o_addr = i_addr;
		for (int k = `HBAD_NUM_MAPS - 1; k >= 0; k--) begin
			if (i_maps[k].en && i_addr[31:16] >= i_maps[k].base &&
				i_addr[31:16] <= i_maps[k].last) begin
				o_hit  = 1'b1;
				o_addr = {i_addr[31:16] + i_maps[k].offs, i_addr[15:0]};
			end
		end
	end

endmodule

// ===== tb/hbad_bus_master.sv
////////////////////////////////////////////////////////////////////////////////
// Processor and PCI bus masters facing the decoder.
module hbad_bus_master
	import hbad_pkg::*;
(
	// Clock.
	input  wire logic          i_clk,
	// Requests.
	output hbad_pkg::hbad_req_t o_cpu,
	output hbad_pkg::hbad_req_t o_pci
);
	initial begin
		o_cpu = '0;
		o_pci = '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One master at a time, one request a cycle, never interleaved.
	task automatic cpu(input logic w, input logic d, input logic [31:0] a,
		input logic [63:0] wd);
		o_cpu <= '{valid:1'b1, write:w, dac:d, addr:a, wdata:wd, be:8'hff};
		@(posedge i_clk);
	endtask

	// Released address and data lines show the inverse of the last value.
	task automatic idle();
		o_cpu <= '{valid:1'b0, write:1'b0, dac:1'b0, addr:~o_cpu.addr,
			wdata:~o_cpu.wdata, be:8'h00};
		@(posedge i_clk);
	endtask

	task automatic pci(input logic [31:0] a);
		o_pci <= '{valid:1'b1, write:1'b0, dac:1'b0, addr:a, wdata:'0,
			be:8'hff};
		@(posedge i_clk);
		o_pci <= '{valid:1'b0, write:1'b0, dac:1'b0, addr:~a, wdata:'1,
			be:8'h00};
		@(posedge i_clk);
	endtask
endmodule

// ===== tb/hbad_top_tb.sv
module hbad_top_tb import hbad_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		hbad_tgt_t tgt;
		logic      err;
		logic      cfg;
	} hbad_exp_t;
	logic        i_clk = 0;
	logic        i_resetn = 0;
	logic        map_we = 0;
	logic        map_dir = 0;
	logic [1:0]  map_idx = 0;
	hbad_map_t   map_wd = '0;
	hbad_req_t   cpu;
	hbad_req_t   pci;
	hbad_route_t route;
	logic        ack, err, psel, perr, boot, mact;
	logic [63:0] rdata, pwd;
	logic [31:0] paddr, rs = 32'h12, a;
	int          fails = 0;
	int          compares = 0;
	hbad_exp_t   eq[$];
	hbad_exp_t   e;
	logic [32:0] pq[$];
	logic [32:0] p;
	logic [31:0] adr [15] = '{32'h7fff_ffff, 32'h8000_0000, 32'h8001_ffff,
		32'h8002_0000, 32'hfef7_ffff, 32'hfef8_0000, 32'hfef8_ffff,
		32'hfef9_0000, 32'hfefe_ffff, 32'hfeff_0000, 32'hfeff_ffff,
		32'hff00_0000, 32'hffef_ffff, 32'hfff0_0000, 32'hffff_ffff};
	hbad_tgt_t   tg [15] = '{HBAD_TGT_NONE, HBAD_TGT_IO, HBAD_TGT_IO,
		HBAD_TGT_NONE, HBAD_TGT_NONE, HBAD_TGT_MCU, HBAD_TGT_MCU,
		HBAD_TGT_NONE, HBAD_TGT_NONE, HBAD_TGT_HB, HBAD_TGT_HB,
		HBAD_TGT_NONE, HBAD_TGT_NONE, HBAD_TGT_ROMA, HBAD_TGT_ROMA};

	always #5 i_clk = ~i_clk;

	hbad_bus_master u_bus (.i_clk(i_clk), .o_cpu(cpu), .o_pci(pci));

	hbad_top u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_cpu(cpu),
		.i_pci(pci), .i_map_we(map_we), .i_map_dir(map_dir),
		.i_map_idx(map_idx), .i_map_wdata(map_wd), .o_cpu_route(route),
		.o_cpu_ack(ack), .o_cpu_err(err), .o_cpu_rdata(rdata),
		.o_pci_wdata(pwd), .o_pci_sel(psel), .o_pci_addr(paddr),
		.o_pci_err(perr), .o_boot_bank_select(boot), .o_map_active(mact));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] s);
		compares++;
		if (s !== x) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, s);
		end
	endtask

	task automatic test_done();
		if (fails == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic go(input logic w, input logic d, input logic [31:0] ad,
		input logic [63:0] wd, input hbad_tgt_t t, input logic er, input logic c);
		eq.push_back('{tgt:t, err:er, cfg:c});
		u_bus.cpu(w, d, ad, wd);
	endtask

	task automatic mapw(input logic dir, input logic [1:0] idx, input hbad_map_t m);
		map_dir <= dir;
		map_idx <= idx;
		map_wd <= m;
		map_we <= 1'b1;
		@(posedge i_clk);
		map_we <= 1'b0;
		@(posedge i_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Watcher pairs each answer with the oldest note.
	always @(posedge i_clk) begin
		if (ack === 1'b1 || err === 1'b1) begin
			e = eq.pop_front();
			cmp("cpu err", 32'(e.err), 32'(err));
			cmp("cpu ack", 32'(!e.err), 32'(ack));
			cmp("cpu sel", 32'(!e.err), 32'(route.sel));
			if (!e.err) cmp("cpu target", 32'(e.tgt), 32'(route.tgt));
			if (e.cfg) cmp("cfg cycle", 32'h1, 32'(route.cfg_cycle));
		end
		if (psel === 1'b1 || perr === 1'b1) begin
			p = pq.pop_front();
			cmp("pci err", 32'(p[32]), 32'(perr));
			if (!p[32]) cmp("pci addr", p[31:0], paddr);
		end
	end

	initial begin
		repeat (5000) @(posedge i_clk);
		fails++;
		test_done();
	end

	initial begin
		repeat (8) @(posedge i_clk);
		i_resetn <= 1'b1;
		@(posedge i_clk);
		pq.push_back({1'b1, 32'h0});
		u_bus.pci(32'h1000_1234);
		for (int i = 0; i < 15; i++) go(0, 0, adr[i], 0, tg[i], tg[i] == HBAD_TGT_NONE, 0);
		for (int i = 0; i < 8; i++) begin
			a = 32'h8000_0000 | (xs() & 32'h0001_fff8);
			go(1, 0, a, {xs(), xs()}, HBAD_TGT_IO, 0, 0);
			go(0, 0, xs() & 32'h7fff_fff8, 0, HBAD_TGT_NONE, 1, 0);
		end
		go(0, 1, 32'h8000_0010, 0, HBAD_TGT_IO, 1, 0);
		go(1, 0, 32'hfef8_0050, 64'h1, HBAD_TGT_MCU, 0, 0);
		u_bus.idle();
		go(0, 0, 32'hfff0_0000, 0, HBAD_TGT_ROMB, 0, 0);
		u_bus.idle();
		cmp("boot bank select", 32'h1, 32'(boot));
		go(1, 0, 32'hfef8_0050, 64'h0, HBAD_TGT_MCU, 0, 0);
		u_bus.idle();
		go(0, 0, 32'hffff_fff8, 0, HBAD_TGT_ROMA, 0, 0);
		go(1, 0, 32'h8000_0cf8, 64'h8000_0800, HBAD_TGT_IO, 0, 0);
		u_bus.idle();
		go(0, 0, 32'h8000_0cfc, 0, HBAD_TGT_IO, 0, 1);
		go(0, 0, 32'h9000_0010, 0, HBAD_TGT_NONE, 1, 0);
		u_bus.idle();
		mapw(0, 2'd0, '{en:1'b1, base:16'h9000, last:16'h9000, offs:16'h0});
		go(0, 0, 32'h9000_0010, 0, HBAD_TGT_MAP, 0, 0);
		u_bus.idle();
		mapw(1, 2'd3, '{en:1'b1, base:16'h1000, last:16'h1000, offs:16'h0010});
		pq.push_back({1'b0, 32'h1010_1234});
		u_bus.pci(32'h1000_1234);
		repeat (4) @(posedge i_clk);
		cmp("pending", 32'h0, 32'(eq.size() + pq.size()));
		test_done();
	end
endmodule
